// ==== bench/dps_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module dps_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic por_active,
  input wire logic supply_above_low_raw,
  input wire logic supply_enable,
  input wire logic [7:0] line_drive_duty,
  input wire logic line_drive_out_oe,
  input wire logic supply_converter_drive_out_oe,
  input wire logic first_phase_loop_en,
  input wire logic second_phase_loop_en,
  input wire logic clamp_blank_out,
  input wire logic line_lock_loss_pin,
  input wire logic line_lock_loss_pin_oe,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  no_ack_clear_a: assert property (
    por_active |-> !pready) else $error("ack during clear");
  zero_wait_a: assert property (
    psel && penable && !por_active |-> pready) else $error("no ack");
  clear_standby_a: assert property (
    por_active |=> !supply_enable && !line_drive_out_oe)
    else $error("clear not standby");
  standby_float_a: assert property (
    !supply_enable |-> !line_drive_out_oe && !supply_converter_drive_out_oe)
    else $error("drive in standby");
  protect_float_a: assert property (
    clamp_blank_out |-> !line_drive_out_oe && !line_lock_loss_pin_oe
    && !first_phase_loop_en && !second_phase_loop_en)
    else $error("protection outputs");
  lock_low_a: assert property (
    !line_lock_loss_pin |-> first_phase_loop_en && line_lock_loss_pin_oe)
    else $error("lock pin low off");
  duty_idle_a: assert property (
    !line_drive_out_oe |-> line_drive_duty == 8'h00) else $error("duty");
  ramp_step_a: assert property (
    $changed(line_drive_duty) && line_drive_out_oe && $past(line_drive_out_oe)
    |=> $stable(line_drive_duty) [*8]) else $error("ramp too fast");
  low_dip_a: assert property (
    $fell(supply_above_low_raw) |-> ##[1:5] !line_drive_out_oe
    && !supply_converter_drive_out_oe) else $error("dip kept drive");
  cover property (clamp_blank_out);
  cover property (!line_lock_loss_pin);
  cover property (irq);
endmodule
bind dps_sequencer dps_checker u_chk (.clk_sys, .rst, .psel, .penable,
  .pready, .por_active, .supply_above_low_raw, .supply_enable,
  .line_drive_duty, .line_drive_out_oe, .supply_converter_drive_out_oe,
  .first_phase_loop_en, .second_phase_loop_en, .clamp_blank_out,
  .line_lock_loss_pin, .line_lock_loss_pin_oe, .irq);
`default_nettype wire

// ==== bench/dps_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dps_host_model #(
  parameter int SETTLE = 20
) (
  input wire logic clk_sys,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [31:0] rd;
  logic err;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // One word per access, since the device never auto-increments.
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do @(posedge clk_sys); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Gives up after three access cycles: only used while the device is mute.
  task automatic probe(output logic seen);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= 1'h0;
    @(posedge clk_sys);
    penable <= 1'h1;
    seen = 1'h0;
    repeat (3) begin
      @(posedge clk_sys);
      seen |= (pready === 1'h1);
    end
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic settle();
    repeat (SETTLE) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic por_active = 1'h1;
  logic supply_above_soft_raw = 1'h0;
  logic supply_above_low_raw = 1'h1;
  logic loop1_locked_raw = 1'h0;
  logic protect_trip_raw = 1'h0;
  logic psel, penable, pwrite, pready, pslverr, irq, seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic supply_enable, line_drive_out_oe, supply_converter_drive_out_oe;
  logic first_phase_loop_en, second_phase_loop_en, clamp_blank_out;
  logic line_lock_loss_pin, line_lock_loss_pin_oe;
  logic [7:0] line_drive_duty, supply_converter_duty, geometry_word, d0;
  int miscompares = 0;
  int comparisons = 0;
  localparam logic [11:0] CT = dps_pkg::DPS_CTRL_OFS;
  localparam logic [11:0] ST = dps_pkg::DPS_STAT_OFS;
  localparam logic [11:0] GM = dps_pkg::DPS_GEOM_OFS;
  localparam logic [11:0] MK = dps_pkg::DPS_MASK_OFS;
  always #5 clk_sys = ~clk_sys;
  dps_sequencer dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .por_active,
    .supply_above_soft_raw, .supply_above_low_raw, .loop1_locked_raw,
    .protect_trip_raw, .supply_enable, .line_drive_duty, .line_drive_out_oe,
    .supply_converter_duty, .supply_converter_drive_out_oe,
    .first_phase_loop_en, .second_phase_loop_en, .clamp_blank_out,
    .line_lock_loss_pin, .line_lock_loss_pin_oe, .geometry_word, .irq);
  dps_host_model #(.SETTLE(20)) host (.clk_sys, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    host.xfer(1'h0, a, 32'h0000_0000);
    chk(host.rd & 32'h0000_00ff, exp);
  endtask
  // Polls the state field; the ramp takes tens of thousands of cycles.
  task automatic wait_state(input logic [2:0] s);
    int n;
    n = 0;
    do begin
      host.xfer(1'h0, ST, 32'h0000_0000);
      n++;
    end while (host.rd[2:0] !== s && n < 15000);
    chk(host.rd[2:0], s);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #600_000;
    miscompares++;
    stop_test();
  end
  initial begin
    tick(10);
    rst <= 1'h0;
    host.probe(seen);
    chk(seen, 1'h0);
    por_active <= 1'h0;
    tick(3);
    rdc(CT, 32'h0000_0001);
    wait_state(3'h0);
    host.xfer(1'h0, 12'h0_100, 32'h0000_0000);
    chk({31'h0, host.err}, 32'h0000_0001);
    chk(host.rd, 32'h0000_0000);
    host.xfer(1'h1, CT, 32'h0000_0000);
    tick(3);
    chk({supply_enable, line_drive_out_oe, line_lock_loss_pin}, 3'h5);
    host.xfer(1'h1, CT, 32'h0000_0002);
    tick(3);
    rdc(CT, 32'h0000_0000);
    supply_above_soft_raw <= 1'h1;
    loop1_locked_raw <= 1'h1;
    host.xfer(1'h1, MK, 32'h0000_0001);
    host.settle();
    host.xfer(1'h1, CT, 32'h0000_0002);
    tick(4);
    chk({first_phase_loop_en, second_phase_loop_en}, 2'h3);
    d0 = line_drive_duty;
    tick(300);
    chk(line_drive_duty > d0 && supply_converter_duty > 8'h00, 1'h1);
    wait_state(3'h3);
    tick(1);
    chk({irq, line_lock_loss_pin}, 2'h2);
    loop1_locked_raw <= 1'h0;
    tick(5);
    chk(line_lock_loss_pin, 1'h1);
    host.xfer(1'h1, MK, 32'h0000_0000);
    tick(1);
    chk(irq, 1'h0);
    host.xfer(1'h1, dps_pkg::DPS_IRQ_OFS, 32'h0000_0001);
    host.xfer(1'h1, MK, 32'h0000_0001);
    tick(1);
    chk(irq, 1'h0);
    host.xfer(1'h1, GM, 32'h0000_005a);
    tick(1);
    chk(geometry_word, 8'h5a);
    rdc(ST, 32'h0000_001b);
    protect_trip_raw <= 1'h1;
    tick(6);
    chk({clamp_blank_out, line_drive_out_oe, line_lock_loss_pin_oe,
         first_phase_loop_en, second_phase_loop_en}, 5'h10);
    rdc(GM, 32'h0000_005a);
    host.xfer(1'h1, CT, 32'h0000_0001);
    protect_trip_raw <= 1'h0;
    wait_state(3'h0);
    rdc(GM, 32'h0000_0000);
    host.xfer(1'h1, CT, 32'h0000_0000);
    host.xfer(1'h1, CT, 32'h0000_0002);
    wait_state(3'h2);
    supply_above_low_raw <= 1'h0;
    tick(6);
    chk(line_drive_out_oe, 1'h0);
    rdc(CT, 32'h0000_0001);
    wait_state(3'h0);
    stop_test();
  end
endmodule
`default_nettype wire

// ==== rtl/dps_pkg.sv ====
// Summary of operation
// RULE1: No bus acknowledge while power-on clear active.
// RULE2: Enter standby when power-on clear ends.
// RULE3: Hold and ramp bits take start values.
// RULE4: Clearing hold enables supply, drives stay off.
// RULE5: Ramp bit set ignored below soft-start threshold.
// RULE6: Host writes one register per transfer.
// RULE7: Host waits before setting ramp bit.
// RULE8: Ramp bit ramps both drives, enables loops.
// RULE9: Lock-loss pin low while first loop locked; code keeps it low only in full operation.
// RULE10: Register writes act immediately in operation.
// RULE11: Leave operation only by ramp clear or dip; code also leaves on protection trip.
// RULE12: Ramp clear starts soft-down of both drives.
// RULE13: Protection floats drives, blanks, stops loops.
// RULE14: Protection left by three defined ways.
// RULE15: Hold bit floats drives, loses other registers; code ignores hold in soft-start and full operation.
// RULE16: Upper dip runs soft-down then soft-start.
// RULE17: Lower dip disables drives, enters standby.
// RULE18: Supply flags synchronised onto device clock.
// RULE19: Ramp step rate and end are parameters.
package dps_pkg;
  localparam logic [11:0] DPS_CTRL_OFS = 12'h0_000;
  localparam logic [11:0] DPS_STAT_OFS = 12'h0_004;
  localparam logic [11:0] DPS_IRQ_OFS = 12'h0_008;
  localparam logic [11:0] DPS_MASK_OFS = 12'h0_00c;
  localparam logic [11:0] DPS_GEOM_OFS = 12'h0_010;
  localparam int DPS_HOLD_BIT = 0;
  localparam int DPS_RAMP_BIT = 1;
  localparam logic DPS_HOLD_RST = 1'b1;
  localparam logic DPS_RAMP_RST = 1'b0;
  localparam int DPS_STEP_DIV = 100;
  localparam logic [7:0] DPS_DUTY_MAX = 8'hff;
  localparam int DPS_NIRQ = 4;
  localparam int DPS_IRQ_FULL = 0;
  localparam int DPS_IRQ_PROT = 1;
  localparam int DPS_IRQ_DIP = 2;
  localparam int DPS_IRQ_ENDDOWN = 3;
  typedef enum logic [2:0] {
    DPS_ST_STANDBY, DPS_ST_IDLE, DPS_ST_SOFTSTART, DPS_ST_FULL,
    DPS_ST_SOFTDOWN, DPS_ST_PROTECT
  } dps_state_t;
endpackage

// ==== rtl/dps_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module dps_sequencer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic por_active,
  input wire logic supply_above_soft_raw,
  input wire logic supply_above_low_raw,
  input wire logic loop1_locked_raw,
  input wire logic protect_trip_raw,
  output logic supply_enable,
  output logic [7:0] line_drive_duty,
  output logic line_drive_out_oe,
  output logic [7:0] supply_converter_duty,
  output logic supply_converter_drive_out_oe,
  output logic first_phase_loop_en,
  output logic second_phase_loop_en,
  output logic clamp_blank_out,
  output logic line_lock_loss_pin,
  output logic line_lock_loss_pin_oe,
  output logic [7:0] geometry_word,
  output logic irq
);
  logic [1:0] soft_s_r, low_s_r, lock_s_r, prot_s_r;
  logic above_soft, above_low, locked, prot;
  logic hold_r, ramp_r, restart_r;
  logic [7:0] geom_r, duty_r;
  logic [$clog2(dps_pkg::DPS_STEP_DIV)-1:0] div_r;
  logic step;
  logic [dps_pkg::DPS_NIRQ-1:0] irq_st_r, irq_mask_r, ev;
  dps_pkg::dps_state_t st_r, st_nxt;
  logic acc, wr, rd, hit;
  logic below_prev_r;

  // Flags come from analog comparators, so each gets two flops. [RULE18]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      soft_s_r <= '0;
      low_s_r <= '0;
      lock_s_r <= '0;
      prot_s_r <= '0;
    end else begin
      soft_s_r <= {soft_s_r[0], supply_above_soft_raw};
      low_s_r <= {low_s_r[0], supply_above_low_raw};
      lock_s_r <= {lock_s_r[0], loop1_locked_raw};
      prot_s_r <= {prot_s_r[0], protect_trip_raw};
    end
  end
  assign above_soft = soft_s_r[1];
  assign above_low = low_s_r[1];
  assign locked = lock_s_r[1];
  assign prot = prot_s_r[1];

  // Power-on clear withholds the bus answer entirely. [RULE1]
  assign acc = psel && penable && !por_active;
  assign pready = acc;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign hit = (paddr == dps_pkg::DPS_CTRL_OFS) ||
               (paddr == dps_pkg::DPS_STAT_OFS) ||
               (paddr == dps_pkg::DPS_IRQ_OFS) ||
               (paddr == dps_pkg::DPS_MASK_OFS) ||
               (paddr == dps_pkg::DPS_GEOM_OFS);
  assign pslverr = acc && !hit;

  // Control bits; forced to start values by power-on clear. [RULE3]
  always_ff @(posedge clk_sys) begin
    if (rst || por_active) begin
      hold_r <= dps_pkg::DPS_HOLD_RST;
      ramp_r <= dps_pkg::DPS_RAMP_RST;
    end else if (!above_low) begin
      hold_r <= 1'b1; // [RULE17]
      ramp_r <= 1'b0;
    end else if (wr && paddr == dps_pkg::DPS_CTRL_OFS) begin
      hold_r <= pwdata[dps_pkg::DPS_HOLD_BIT];
      // Set attempts below the soft-start threshold are dropped. [RULE5]
      if (pwdata[dps_pkg::DPS_RAMP_BIT] && !above_soft) begin
        ramp_r <= ramp_r && !hold_r;
      end else begin
        ramp_r <= pwdata[dps_pkg::DPS_RAMP_BIT];
      end
    end
  end

  // Geometry register stands in for the adjustment set; takes effect at
  // once in operation and is lost in standby. [RULE10] [RULE15]
  always_ff @(posedge clk_sys) begin
    if (rst || st_r == dps_pkg::DPS_ST_STANDBY) begin
      geom_r <= 8'h00;
    end else if (wr && paddr == dps_pkg::DPS_GEOM_OFS) begin
      geom_r <= pwdata[7:0];
    end
  end
  assign geometry_word = geom_r;

  // Ramp step timer; rate and end are package constants. [RULE19]
  always_ff @(posedge clk_sys) begin
    if (rst || div_r == $bits(div_r)'(dps_pkg::DPS_STEP_DIV - 1)) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end
  assign step = (div_r == $bits(div_r)'(dps_pkg::DPS_STEP_DIV - 1));

  // Starts as if already below, so reset with the supply still low does
  // not log a false dip event.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      below_prev_r <= 1'b1;
    end else begin
      below_prev_r <= !above_soft;
    end
  end

  // Upper dip remembers that a fresh soft-start must follow. [RULE16]
  always_ff @(posedge clk_sys) begin
    if (rst || st_r == dps_pkg::DPS_ST_STANDBY) begin
      restart_r <= 1'b0;
    end else if (st_r == dps_pkg::DPS_ST_FULL && !above_soft) begin
      restart_r <= 1'b1;
    end else if (st_r == dps_pkg::DPS_ST_SOFTSTART) begin
      restart_r <= 1'b0;
    end
  end

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      dps_pkg::DPS_ST_STANDBY: begin
        if (!hold_r) st_nxt = dps_pkg::DPS_ST_IDLE; // [RULE4]
      end
      dps_pkg::DPS_ST_IDLE: begin
        if (hold_r) st_nxt = dps_pkg::DPS_ST_STANDBY;
        else if (ramp_r) st_nxt = dps_pkg::DPS_ST_SOFTSTART; // [RULE8]
      end
      dps_pkg::DPS_ST_SOFTSTART: begin
        if (!ramp_r) st_nxt = dps_pkg::DPS_ST_SOFTDOWN;
        else if (prot) st_nxt = dps_pkg::DPS_ST_PROTECT;
        else if (duty_r == dps_pkg::DPS_DUTY_MAX) begin
          st_nxt = dps_pkg::DPS_ST_FULL;
        end
      end
      dps_pkg::DPS_ST_FULL: begin
        // Only ramp clear, protection trip or a dip ends operation. [RULE11]
        if (!ramp_r || !above_soft) st_nxt = dps_pkg::DPS_ST_SOFTDOWN;
        else if (prot) st_nxt = dps_pkg::DPS_ST_PROTECT;
      end
      dps_pkg::DPS_ST_SOFTDOWN: begin
        if (duty_r == 8'h00) begin
          if (restart_r && ramp_r && above_soft) begin
            st_nxt = dps_pkg::DPS_ST_SOFTSTART; // [RULE16]
          end else if (hold_r) begin
            st_nxt = dps_pkg::DPS_ST_STANDBY;
          end else if (!restart_r) begin
            st_nxt = dps_pkg::DPS_ST_IDLE;
          end
        end
      end
      dps_pkg::DPS_ST_PROTECT: begin
        // Exit by ramp set once the trip clears, or ramp clear with hold set. [RULE14]
        if (ramp_r && !prot) st_nxt = dps_pkg::DPS_ST_SOFTSTART;
        else if (!ramp_r && hold_r) st_nxt = dps_pkg::DPS_ST_STANDBY;
      end
      default: st_nxt = dps_pkg::DPS_ST_STANDBY;
    endcase
    // Lower dip overrides everything, in any mode. [RULE17] [RULE14]
    if (!above_low) st_nxt = dps_pkg::DPS_ST_STANDBY;
  end

  // Power-on clear lands in standby. [RULE2]
  always_ff @(posedge clk_sys) begin
    if (rst || por_active) begin
      st_r <= dps_pkg::DPS_ST_STANDBY;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Duty ramps up in soft-start and down in soft-down. [RULE8] [RULE12]
  always_ff @(posedge clk_sys) begin
    if (rst || st_nxt == dps_pkg::DPS_ST_STANDBY ||
        st_nxt == dps_pkg::DPS_ST_IDLE ||
        st_nxt == dps_pkg::DPS_ST_PROTECT) begin
      duty_r <= 8'h00;
    end else if (step && st_r == dps_pkg::DPS_ST_SOFTSTART &&
                 duty_r != dps_pkg::DPS_DUTY_MAX) begin
      duty_r <= duty_r + 8'h01;
    end else if (step && st_r == dps_pkg::DPS_ST_SOFTDOWN &&
                 duty_r != 8'h00) begin
      duty_r <= duty_r - 8'h01;
    end
  end

  // Outputs decode the state; protection floats drives and lock pin,
  // blanks continuously and stops loops. [RULE13] [RULE15] [RULE4]
  logic driving;
  assign driving = (st_r == dps_pkg::DPS_ST_SOFTSTART) ||
                   (st_r == dps_pkg::DPS_ST_FULL) ||
                   (st_r == dps_pkg::DPS_ST_SOFTDOWN);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      supply_enable <= 1'b0;
      line_drive_duty <= 8'h00;
      supply_converter_duty <= 8'h00;
      line_drive_out_oe <= 1'b0;
      supply_converter_drive_out_oe <= 1'b0;
      first_phase_loop_en <= 1'b0;
      second_phase_loop_en <= 1'b0;
      clamp_blank_out <= 1'b0;
      line_lock_loss_pin <= 1'b1;
      line_lock_loss_pin_oe <= 1'b1;
    end else begin
      supply_enable <= st_r != dps_pkg::DPS_ST_STANDBY;
      // A lower dip drops the duty together with the enables. [RULE17]
      line_drive_duty <= (driving && above_low) ? duty_r : 8'h00;
      supply_converter_duty <= (driving && above_low) ? duty_r : 8'h00;
      line_drive_out_oe <= driving && above_low;
      supply_converter_drive_out_oe <= driving && above_low;
      first_phase_loop_en <= driving;
      second_phase_loop_en <= driving;
      clamp_blank_out <= st_r == dps_pkg::DPS_ST_PROTECT;
      // Low only while locked in full operation. [RULE9]
      line_lock_loss_pin <= !(st_r == dps_pkg::DPS_ST_FULL && locked);
      line_lock_loss_pin_oe <= st_r != dps_pkg::DPS_ST_PROTECT;
    end
  end

  // Sticky events; set wins over a write-one clear in the same cycle.
  assign ev[dps_pkg::DPS_IRQ_FULL] = st_nxt == dps_pkg::DPS_ST_FULL &&
                                     st_r != dps_pkg::DPS_ST_FULL;
  assign ev[dps_pkg::DPS_IRQ_PROT] = st_nxt == dps_pkg::DPS_ST_PROTECT &&
                                     st_r != dps_pkg::DPS_ST_PROTECT;
  assign ev[dps_pkg::DPS_IRQ_DIP] = !above_soft && !below_prev_r;
  assign ev[dps_pkg::DPS_IRQ_ENDDOWN] = st_r == dps_pkg::DPS_ST_SOFTDOWN &&
                                        st_nxt != dps_pkg::DPS_ST_SOFTDOWN;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_st_r <= '0;
    end else if (wr && paddr == dps_pkg::DPS_IRQ_OFS) begin
      irq_st_r <= (irq_st_r & ~pwdata[dps_pkg::DPS_NIRQ-1:0]) | ev;
    end else begin
      irq_st_r <= irq_st_r | ev;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_mask_r <= '0;
    end else if (wr && paddr == dps_pkg::DPS_MASK_OFS) begin
      irq_mask_r <= pwdata[dps_pkg::DPS_NIRQ-1:0];
    end
  end
  assign irq = |(irq_st_r & irq_mask_r);

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      unique case (paddr)
        dps_pkg::DPS_CTRL_OFS: prdata = {30'h0, ramp_r, hold_r};
        dps_pkg::DPS_STAT_OFS: prdata = {16'h0, duty_r, 1'b0, prot,
                                         locked, above_low, above_soft,
                                         st_r};
        dps_pkg::DPS_IRQ_OFS: prdata = {28'h0, irq_st_r};
        dps_pkg::DPS_MASK_OFS: prdata = {28'h0, irq_mask_r};
        dps_pkg::DPS_GEOM_OFS: prdata = {24'h0, geom_r};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire
